// ---- core/gpt_timer.sv ----
module gpt_timer
    import gpt_pkg::*;
#(
    parameter bit HAS_EXT_CLK = 1'b1
) (
    input  wire logic        CLK_I,
    input  wire logic        RSTN_I,
    input  wire logic        CYC_I,
    input  wire logic        STB_I,
    input  wire logic        WE_I,
    input  wire logic [7:0]  ADR_I,
    input  wire logic [3:0]  SEL_I,
    input  wire logic [31:0] DAT_I,
    output logic      [31:0] DAT_O,
    output logic             ACK_O,
    input  wire logic        EXT_CLK_I,
    output logic             IRQ_O,
    output logic             DMA_EVT_O
);

    // ========================================
    // byte-lane merge
    function automatic logic [31:0] merge(input logic [31:0] old_v,
                                          input logic [31:0] new_v,
                                          input logic [3:0]  sel);
        logic [31:0] r;
        r = old_v;
        for (int i = 0; i < 4; i++) begin
            if (sel[i]) begin
                r[i*8 +: 8] = new_v[i*8 +: 8];
            end
        end
        return r;
    endfunction

    // ========================================
    // register word packing
    // field positions live in the package so software and logic cannot drift apart
    function automatic logic [31:0] tcr_pack(input gpt_tcr_t t);
        logic [31:0] w;
        w = 32'h0;
        w[TCR_RUN_LO_POS +: 2] = t.run_lo;
        w[TCR_CLKSRC_POS]      = t.clk_src;
        w[TCR_GATE_POS]        = t.gate;
        w[TCR_RUN_HI_POS +: 2] = t.run_hi;
        return w;
    endfunction

    function automatic gpt_tcr_t tcr_unpack(input logic [31:0] w);
        gpt_tcr_t t;
        t.run_lo  = gpt_run_t'(w[TCR_RUN_LO_POS +: 2]);
        t.clk_src = w[TCR_CLKSRC_POS];
        t.gate    = w[TCR_GATE_POS];
        t.run_hi  = gpt_run_t'(w[TCR_RUN_HI_POS +: 2]);
        return t;
    endfunction

    function automatic logic [31:0] gcr_pack(input gpt_gcr_t g);
        logic [31:0] w;
        w = 32'h0;
        w[GCR_RS_LO_POS]       = g.rs_lo;
        w[GCR_RS_HI_POS]       = g.rs_hi;
        w[GCR_WIDTH_POS +: 2]  = g.width;
        return w;
    endfunction

    function automatic gpt_gcr_t gcr_unpack(input logic [31:0] w);
        gpt_gcr_t g;
        g.rs_lo = w[GCR_RS_LO_POS];
        g.rs_hi = w[GCR_RS_HI_POS];
        g.width = gpt_width_t'(w[GCR_WIDTH_POS +: 2]);
        return g;
    endfunction

    // reserved run code counts as stopped
    function automatic logic run_active(input gpt_run_t mode,
                                        input logic     done);
        return (mode == GPT_RUN_CONT) | ((mode == GPT_RUN_ONCE) & ~done);
    endfunction

    // ========================================
    // bus decode
    logic        ack_q;
    logic [31:0] dat_q;
    logic [63:0] cnt_q;
    logic [63:0] cnt_d;
    logic [63:0] prd_q;
    logic [31:0] shadow_q;
    gpt_tcr_t    tcr_q;
    gpt_gcr_t    gcr_q;
    gpt_evt_t    evt_q;
    gpt_evt_t    evt_d;
    logic        done_q;
    logic        ext_s1_q;
    logic        ext_s2_q;
    logic        ext_s3_q;

    wire         acc        = CYC_I & STB_I & ~ack_q;
    wire         wr         = acc & WE_I;
    wire         rd         = acc & ~WE_I;
    wire         hit_cnt_lo = (ADR_I == ADDR_CNT_LO);
    wire         hit_cnt_hi = (ADR_I == ADDR_CNT_HI);
    wire         hit_prd_lo = (ADR_I == ADDR_PRD_LO);
    wire         hit_prd_hi = (ADR_I == ADDR_PRD_HI);
    wire         hit_tcr    = (ADR_I == ADDR_TCR);
    wire         hit_gcr    = (ADR_I == ADDR_GCR);
    wire         mode64     = (gcr_q.width == GPT_W64);
    wire [31:0]  tcr_word   = tcr_pack(tcr_q);
    wire [31:0]  gcr_word   = gcr_pack(gcr_q);
    wire         wr_tcr     = wr & hit_tcr;
    wire         wr_gcr     = wr & hit_gcr;
    wire         wr_prd_lo  = wr & hit_prd_lo;
    wire         wr_prd_hi  = wr & hit_prd_hi;
    wire         rd_cnt_lo  = rd & hit_cnt_lo;
    wire gpt_tcr_t tcr_nxt  = tcr_unpack(merge(tcr_word, DAT_I, SEL_I));
    wire gpt_gcr_t gcr_nxt  = gcr_unpack(merge(gcr_word, DAT_I, SEL_I));
    wire [31:0]  cnt_hi_rd  = mode64 ? shadow_q : cnt_q[63:32];

    wire [31:0]  rd_data    = hit_cnt_lo ? cnt_q[31:0] :
                              hit_cnt_hi ? cnt_hi_rd   :
                              hit_prd_lo ? prd_q[31:0] :
                              hit_prd_hi ? prd_q[63:32] :
                              hit_tcr    ? tcr_word    :
                              hit_gcr    ? gcr_word    : 32'h0;

    // ========================================
    // clock source and tick
    // the pin is sampled twice before use; the third stage only feeds edge detection
    wire         use_ext    = HAS_EXT_CLK & tcr_q.clk_src;
    wire         ext_rise   = ext_s2_q & ~ext_s3_q;
    // unchained high half would run internally; dual modes beyond width select not built
    wire         tick       = use_ext ? ext_rise : 1'b1;
    wire         in_reset   = ~(gcr_q.rs_lo & gcr_q.rs_hi);
    wire         running    = run_active(tcr_q.run_lo, done_q);
    wire         at_prd     = (cnt_q == prd_q);
    wire         zero_pair  = (prd_q == CNT_ZERO);
    wire         step       = ~in_reset & running & tick & ~zero_pair;
    wire         match      = step & at_prd;

    always_comb begin
        cnt_d = cnt_q;
        if (in_reset) begin
            cnt_d = CNT_ZERO;
        end else if (step) begin
            if (at_prd) begin
                cnt_d = (tcr_q.run_lo == GPT_RUN_CONT) ? CNT_ZERO : cnt_q;
            end else begin
                cnt_d = cnt_q + CNT_ONE;
            end
        end
        if (wr & hit_cnt_lo) begin
            cnt_d[31:0] = merge(cnt_q[31:0], DAT_I, SEL_I);
        end
        if (wr & hit_cnt_hi) begin
            cnt_d[63:32] = merge(cnt_q[63:32], DAT_I, SEL_I);
        end
    end

    assign evt_d = '{irq: match, dma_evt: match};

    // ========================================
    // registers
    always_ff @(posedge CLK_I or negedge RSTN_I) begin
        if (!RSTN_I) begin
            ext_s1_q <= 1'b0;
            ext_s2_q <= 1'b0;
            ext_s3_q <= 1'b0;
        end else begin
            ext_s1_q <= EXT_CLK_I;
            ext_s2_q <= ext_s1_q;
            ext_s3_q <= ext_s2_q;
        end
    end

    always_ff @(posedge CLK_I or negedge RSTN_I) begin
        if (!RSTN_I) begin
            ack_q <= 1'b0;
            dat_q <= 32'h0;
        end else begin
            ack_q <= acc;
            dat_q <= rd ? rd_data : 32'h0;
        end
    end

    always_ff @(posedge CLK_I or negedge RSTN_I) begin
        if (!RSTN_I) begin
            tcr_q <= TCR_RESET;
        end else if (wr_tcr) begin
            tcr_q <= tcr_nxt;
        end
    end

    always_ff @(posedge CLK_I or negedge RSTN_I) begin
        if (!RSTN_I) begin
            gcr_q <= GCR_RESET;
        end else if (wr_gcr) begin
            gcr_q <= gcr_nxt;
        end
    end

    always_ff @(posedge CLK_I or negedge RSTN_I) begin
        if (!RSTN_I) begin
            prd_q <= CNT_ZERO;
        end else begin
            if (wr_prd_lo) begin
                prd_q[31:0] <= merge(prd_q[31:0], DAT_I, SEL_I);
            end
            if (wr_prd_hi) begin
                prd_q[63:32] <= merge(prd_q[63:32], DAT_I, SEL_I);
            end
        end
    end

    // one-shot completion clears when software rewrites the control word
    always_ff @(posedge CLK_I or negedge RSTN_I) begin
        if (!RSTN_I) begin
            done_q <= 1'b0;
        end else if (match & (tcr_q.run_lo == GPT_RUN_ONCE)) begin
            // a match in the same cycle as a control write still stops the run
            done_q <= 1'b1;
        end else if (in_reset | wr_tcr) begin
            done_q <= 1'b0;
        end
    end

    always_ff @(posedge CLK_I or negedge RSTN_I) begin
        if (!RSTN_I) begin
            cnt_q <= CNT_ZERO;
        end else begin
            cnt_q <= cnt_d;
        end
    end

    // snapshot only on a low-word read, so the high word stays coherent when width is GPT_W64 (other widths read it live)
    always_ff @(posedge CLK_I or negedge RSTN_I) begin
        if (!RSTN_I) begin
            shadow_q <= 32'h0;
        end else if (rd_cnt_lo) begin
            shadow_q <= cnt_q[63:32];
        end
    end

    always_ff @(posedge CLK_I or negedge RSTN_I) begin
        if (!RSTN_I) begin
            evt_q <= '0;
        end else begin
            evt_q <= evt_d;
        end
    end

    assign DAT_O     = dat_q;
    assign ACK_O     = ack_q;
    assign IRQ_O     = evt_q.irq;
    assign DMA_EVT_O = evt_q.dma_evt;

endmodule

// ---- core/gpt_pkg.sv ----
package gpt_pkg;

    // ========================================
    // register word offsets (byte addresses)
    localparam logic [7:0] ADDR_CNT_LO  = 8'h10;
    localparam logic [7:0] ADDR_CNT_HI  = 8'h14;
    localparam logic [7:0] ADDR_PRD_LO  = 8'h18;
    localparam logic [7:0] ADDR_PRD_HI  = 8'h1C;
    localparam logic [7:0] ADDR_TCR     = 8'h20;
    localparam logic [7:0] ADDR_GCR     = 8'h24;

    // ========================================
    // control register fields
    localparam int TCR_RUN_LO_POS   = 6;
    localparam int TCR_CLKSRC_POS   = 8;
    localparam int TCR_GATE_POS     = 9;
    localparam int TCR_RUN_HI_POS   = 22;
    localparam int GCR_RS_LO_POS    = 0;
    localparam int GCR_RS_HI_POS    = 1;
    localparam int GCR_WIDTH_POS    = 2;

    typedef enum logic [1:0] {
        GPT_W64       = 2'h0,
        GPT_UNCHAINED = 2'h1,
        GPT_RSVD      = 2'h2,
        GPT_CHAINED   = 2'h3
    } gpt_width_t;

    typedef enum logic [1:0] {
        GPT_RUN_OFF   = 2'h0,
        GPT_RUN_ONCE  = 2'h1,
        GPT_RUN_CONT  = 2'h2,
        GPT_RUN_RSVD  = 2'h3
    } gpt_run_t;

    typedef struct packed {
        gpt_run_t   run_hi;
        logic       gate;
        logic       clk_src;
        gpt_run_t   run_lo;
    } gpt_tcr_t;

    typedef struct packed {
        gpt_width_t width;
        logic       rs_hi;
        logic       rs_lo;
    } gpt_gcr_t;

    typedef struct packed {
        logic irq;
        logic dma_evt;
    } gpt_evt_t;

    localparam gpt_tcr_t TCR_RESET = '{run_hi: GPT_RUN_OFF, gate: 1'b0, clk_src: 1'b0,
                                       run_lo: GPT_RUN_OFF};
    localparam gpt_gcr_t GCR_RESET = '{width: GPT_W64, rs_hi: 1'b0, rs_lo: 1'b0};
    localparam logic [63:0] CNT_ZERO = 64'h0;
    localparam logic [63:0] CNT_ONE  = 64'h1;

endpackage

// ---- tb/gpt_timer_props.sv ----
module gpt_timer_props
    import gpt_pkg::*;
(
    input wire logic        CLK_I,
    input wire logic        RSTN_I,
    input wire logic        CYC_I,
    input wire logic        STB_I,
    input wire logic        WE_I,
    input wire logic [7:0]  ADR_I,
    input wire logic [3:0]  SEL_I,
    input wire logic [31:0] DAT_I,
    input wire logic [31:0] DAT_O,
    input wire logic        ACK_O,
    input wire logic        EXT_CLK_I,
    input wire logic        IRQ_O,
    input wire logic        DMA_EVT_O
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge CLK_I); endclocking
    default disable iff (!RSTN_I);
    wire logic mapped = ADR_I inside {ADDR_CNT_LO, ADDR_CNT_HI, ADDR_PRD_LO, ADDR_PRD_HI,
                                      ADDR_TCR, ADDR_GCR};
    sequence s_req;
        CYC_I && STB_I && !ACK_O;
    endsequence
    sequence s_rd_unmapped;
        ACK_O && !WE_I && !mapped;
    endsequence
    a_ack_latency: assert property (s_req |=> ACK_O) else $error("ack missing");
    a_ack_pulse: assert property (ACK_O |=> !ACK_O) else $error("ack too long");
    a_ack_in_cycle: assert property (ACK_O |-> CYC_I && STB_I) else $error("stray ack");
    a_dat_idle_zero: assert property (!ACK_O |-> DAT_O == 32'h0) else $error("data idle");
    a_unmapped_zero: assert property (s_rd_unmapped |-> DAT_O == 32'h0) else $error("hole");
    a_irq_dma_pair: assert property (IRQ_O == DMA_EVT_O) else $error("event split");
    a_irq_pulse: assert property (IRQ_O |=> !IRQ_O) else $error("irq too long");
    // no match possible before release bits are written
    a_quiet_after_reset: assert property ($rose(RSTN_I) |-> !IRQ_O [*3]) else $error("irq");
endmodule

// ---- tb/tb_top.sv ----
module tb_top;
    import gpt_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;
    logic        clk  = 1'b0;
    logic        rstn = 1'b0;
    logic        cyc  = 1'b0;
    logic        stb  = 1'b0;
    logic        we   = 1'b0;
    logic        ext  = 1'b0;
    logic [7:0]  adr  = 8'h00;
    logic [31:0] dat  = 32'h0;
    logic [31:0] q;
    logic [31:0] rd;
    logic        ack;
    logic        irq;
    logic        dma;
    int          n_errors = 0;
    int          checks = 0;
    int          c;
    always #2.5 clk = ~clk;
    gpt_timer #(.HAS_EXT_CLK(1'b1)) i_dut (.CLK_I(clk), .RSTN_I(rstn), .CYC_I(cyc),
        .STB_I(stb), .WE_I(we), .ADR_I(adr), .SEL_I(4'hF), .DAT_I(dat), .DAT_O(q),
        .ACK_O(ack), .EXT_CLK_I(ext), .IRQ_O(irq), .DMA_EVT_O(dma));
    // ========================================
    // helpers
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            n_errors++;
            $display("BAD %0t got %h want %h", $time, got, exp);
        end
    endtask
    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        cyc <= 1'b1;
        stb <= 1'b1;
        we  <= w;
        adr <= a;
        dat <= d;
        do begin
            @(posedge clk);
        end while (ack !== 1'b1);
        rd = q;
        chk({31'h0, ack}, 32'h1);
        cyc <= 1'b0;
        stb <= 1'b0;
    endtask
    task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
        wb(1'b0, a, 32'h0);
        chk(rd, exp);
    endtask
    task automatic wirq(input int lim);
        c = 0;
        while (irq !== 1'b1 && c < lim) begin
            @(posedge clk);
            c++;
        end
    endtask
    // halves pass through reset, so the count starts from zero
    task automatic setup(input logic [31:0] prd, input logic [31:0] timer_control_reg);
        wb(1'b1, ADDR_TCR, 32'h0);
        wb(1'b1, ADDR_GCR, 32'h0);
        wb(1'b1, ADDR_GCR, 32'h3);
        wb(1'b1, ADDR_PRD_LO, prd);
        wb(1'b1, ADDR_PRD_HI, 32'h0);
        wb(1'b1, ADDR_TCR, timer_control_reg);
    endtask
    task automatic finish_test;
        $display("checks %0d errors %0d", checks, n_errors);
        if (n_errors == 0 && checks > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    // ========================================
    // scenarios
    task automatic t_reset;
        rdc(ADDR_GCR, 32'h0);
        rdc(ADDR_TCR, 32'h0);
        rdc(8'h04, 32'h0);
        rdc(ADDR_CNT_LO, 32'h0);
        $display("t_reset done");
    endtask
    task automatic t_once;
        setup(32'd5, 32'h40);
        wirq(40);
        chk(32'(c < 40), 32'h1);
        @(posedge clk);
        wirq(30);
        chk(32'(c), 32'd30);
        rdc(ADDR_CNT_LO, 32'd5);
        wb(1'b1, ADDR_TCR, 32'h0080_0000);
        repeat (20) @(posedge clk);
        rdc(ADDR_CNT_LO, 32'd5);
        $display("t_once done");
    endtask
    task automatic t_cont;
        setup(32'd3, 32'h80);
        wirq(40);
        @(posedge clk);
        wirq(40);
        chk(32'(c), 32'd3);
        setup(32'd0, 32'h80);
        repeat (20) @(posedge clk);
        rdc(ADDR_CNT_LO, 32'h0);
        $display("t_cont done");
    endtask
    task automatic t_shadow;
        wb(1'b1, ADDR_TCR, 32'h0);
        wb(1'b1, ADDR_CNT_HI, 32'h1);
        wb(1'b1, ADDR_CNT_LO, 32'hFFFF_FFF0);
        wb(1'b1, ADDR_PRD_HI, 32'h3);
        wb(1'b1, ADDR_TCR, 32'h80);
        wb(1'b0, ADDR_CNT_LO, 32'h0);
        repeat (30) @(posedge clk);
        rdc(ADDR_CNT_HI, 32'h1);
        wb(1'b0, ADDR_CNT_LO, 32'h0);
        rdc(ADDR_CNT_HI, 32'h2);
        $display("t_shadow done");
    endtask
    task automatic t_ext;
        setup(32'd100, 32'h180);
        repeat (4) begin
            repeat (4) @(posedge clk);
            ext <= 1'b1;
            repeat (4) @(posedge clk);
            ext <= 1'b0;
        end
        repeat (6) @(posedge clk);
        rdc(ADDR_CNT_LO, 32'd4);
        $display("t_ext done");
    endtask
    initial begin
        repeat (10) @(posedge clk);
        rstn <= 1'b1;
        t_reset;
        t_once;
        t_cont;
        t_shadow;
        t_ext;
        finish_test;
    end
    initial begin
        #200us;
        n_errors++;
        finish_test;
    end
endmodule
bind gpt_timer gpt_timer_props i_props (.CLK_I(CLK_I), .RSTN_I(RSTN_I), .CYC_I(CYC_I),
    .STB_I(STB_I), .WE_I(WE_I), .ADR_I(ADR_I), .SEL_I(SEL_I), .DAT_I(DAT_I),
    .DAT_O(DAT_O), .ACK_O(ACK_O), .EXT_CLK_I(EXT_CLK_I), .IRQ_O(IRQ_O),
    .DMA_EVT_O(DMA_EVT_O));
